// ==== logic/cidt_decode_top.sv ====
// Decode and execute control for the later part of the instruction set.
// Summary of operation
// - OR into accumulator; carry, subtract cleared; parity.
// - Output register r to port-select port, 12.
// - Output accumulator to immediate port n, 11.
// - Repeating block output: 21 per repeat, 16 last.
// - Single block output, 16; zero when counter ends.
// - Pop: low from SP, high from SP+1.
// - Push: high at SP-1, low at SP-2.
// - Index pop/push via prefix: 14 and 15.
// - Bit clear, no flags: 8, 15, 23.
// - Bit set; indexed form 23 states.
// - Return; conditional 5 false, 11 true.
// - Interrupt returns: two bytes, 14 states.
// - Circular left rotate: bit7 to bit0, carry.
// - Digit rotates with memory, 18 states, parity.
// - Accumulator rotates 4 states; carry changes, N and H cleared.
// - Restart pushes PC, jumps to t times eight.
// - 16-bit subtract with carry from pointer, 15.
// - 8-bit subtract with carry, overflow reported.
// - Plain subtract: 4, 7 or 19 states.
// - Exclusive OR with parity: 4, 7, 19.
// - Carry force: carry one, N and H cleared.
// - Shifts: parity, N and H cleared; 8/15/23.
`timescale 1ns/1ps
`default_nettype none
module cidt_decode_top (
	input  wire logic                  CLK_SYS_I,
	input  wire logic                  RESET_I,
	input  wire logic                  INSN_VALID_I,
	input  wire logic [7:0]            INSN_BYTE0_I,
	input  wire logic [7:0]            INSN_BYTE1_I,
	input  wire logic [7:0]            INSN_BYTE2_I,
	input  wire logic [7:0]            INSN_BYTE3_I,
	input  wire logic [7:0]            ACC_I,
	input  wire logic [7:0]            OPERAND_I,
	input  wire logic [7:0]            FLAGS_I,
	input  wire logic [7:0]            PORT_SEL_I,
	input  wire logic [7:0]            COUNT_I,
	input  wire logic [15:0]           MEM_POINTER_I,
	input  wire logic [15:0]           PAIR_VALUE_I,
	input  wire logic [15:0]           STACK_PTR_I,
	input  wire logic [15:0]           PC_I,
	output logic                       DONE_O,
	output logic                       KNOWN_O,
	output cidt_pkg::cidt_class_t      CLASS_O,
	output logic      [2:0]            LENGTH_O,
	output logic      [4:0]            TSTATES_O,
	output logic      [2:0]            REG_SEL_O,
	output logic                       MEM_OPERAND_O,
	output logic      [1:0]            INDEX_SEL_O,
	output logic      [1:0]            PAIR_SEL_O,
	output logic      [7:0]            RESULT_O,
	output logic      [7:0]            MEM_RESULT_O,
	output logic      [15:0]           RESULT16_O,
	output logic      [7:0]            FLAGS_O,
	output logic      [7:0]            FLAG_MASK_O,
	output logic      [7:0]            COUNT_O,
	output logic                       REPEAT_O,
	output logic                       PORT_WRITE_O,
	output logic      [7:0]            PORT_ADDR_O,
	output logic      [7:0]            PORT_DATA_O,
	output logic                       STACK_READ_O,
	output logic                       STACK_WRITE_O,
	output logic      [15:0]           STACK_LO_ADDR_O,
	output logic      [15:0]           STACK_HI_ADDR_O,
	output logic      [7:0]            PUSH_HI_DATA_O,
	output logic      [7:0]            PUSH_LO_DATA_O,
	output logic      [15:0]           NEW_SP_O,
	output logic                       PC_LOAD_O,
	output logic                       PC_FROM_STACK_O,
	output logic      [15:0]           PC_TARGET_O
);
	typedef struct packed {
		logic                  done;
		logic                  known;
		cidt_pkg::cidt_class_t cls;
		logic [2:0]            len;
		logic [4:0]            tst;
		logic [2:0]            reg_sel;
		logic                  mem_op;
		logic [1:0]            idx_sel;
		logic [1:0]            pair_sel;
		logic [7:0]            res;
		logic [7:0]            mem_res;
		logic [15:0]           res16;
		logic [7:0]            flags;
		logic [7:0]            mask;
		logic [7:0]            count;
		logic                  repeat_on;
		logic                  port_wr;
		logic [7:0]            port_addr;
		logic [7:0]            port_data;
		logic                  stk_rd;
		logic                  stk_wr;
		logic [15:0]           stk_lo;
		logic [15:0]           stk_hi;
		logic [7:0]            push_hi;
		logic [7:0]            push_lo;
		logic [15:0]           new_sp;
		logic                  pc_load;
		logic                  pc_stack;
		logic [15:0]           pc_target;
	} cidt_state_t;

	cidt_state_t           st_ff;
	cidt_state_t           nxt_st;
	cidt_pkg::cidt_class_t cls;
	logic [2:0]            sub;
	logic [7:0]            alu_res;
	logic [7:0]            alu_res2;
	logic [15:0]           alu_res16;
	logic [7:0]            alu_flags;

	// Condition test of the three-bit condition field against the flags.
	function automatic logic cond_true(input logic [2:0] condition_field, input logic [7:0] f);
		logic t;
		t = 1'b0;
		case (condition_field[2:1])
			2'h0: t = f[cidt_pkg::FLG_Z];
			2'h1: t = f[cidt_pkg::FLG_C];
			2'h2: t = f[cidt_pkg::FLG_PV];
			default: t = f[cidt_pkg::FLG_S];
		endcase
		cond_true = (t == condition_field[0]);
	endfunction : cond_true

	cidt_alu u_alu (
		.op_i    (cls),
		.sub_i   (sub),
		.a_i     (ACC_I),
		.m_i     ((cls == cidt_pkg::CLS_ACC_ROT) ? ACC_I : OPERAND_I),
		.flags_i (FLAGS_I),
		.hl_i    (MEM_POINTER_I),
		.pair_i  (PAIR_VALUE_I),
		.res_o   (alu_res),
		.res2_o  (alu_res2),
		.res16_o (alu_res16),
		.flags_o (alu_flags)
	);

	always_comb
	begin
		logic       idx;
		logic       ext;
		logic       bitp;
		logic [7:0] op;
		logic [7:0] cnt;
		logic [4:0] t_reg;
		logic [4:0] t_mem;
		logic [4:0] t_idx;
		idx   = (INSN_BYTE0_I == cidt_pkg::PFX_FIRST_INDEX) ||
		        (INSN_BYTE0_I == cidt_pkg::PFX_SECOND_INDEX);
		ext   = (INSN_BYTE0_I == cidt_pkg::PFX_EXTENDED);
		bitp  = (INSN_BYTE0_I == cidt_pkg::PFX_BIT_OP) ||
		        (idx && INSN_BYTE1_I == cidt_pkg::PFX_BIT_OP);
		// The indexed bit form carries its displacement before the final opcode byte.
		op    = (idx && bitp) ? INSN_BYTE3_I : ((idx || bitp || ext) ? INSN_BYTE1_I : INSN_BYTE0_I);
		cnt   = COUNT_I - 8'h01;
		t_reg = cidt_pkg::T_4;
		t_mem = cidt_pkg::T_7;
		t_idx = cidt_pkg::T_19;
		cls   = cidt_pkg::CLS_NONE;
		sub   = op[5:3];
		nxt_st           = st_ff;
		nxt_st.done      = INSN_VALID_I;
		nxt_st.port_wr   = 1'b0;
		nxt_st.stk_rd    = 1'b0;
		nxt_st.stk_wr    = 1'b0;
		nxt_st.pc_load   = 1'b0;
		nxt_st.pc_stack  = 1'b0;
		nxt_st.repeat_on = 1'b0;
		nxt_st.mask      = 8'h00;
		nxt_st.len       = 3'h1;
		nxt_st.reg_sel   = op[2:0];
		nxt_st.mem_op    = (op[2:0] == cidt_pkg::REG_MEM) && !ext;
		nxt_st.idx_sel   = idx ? (INSN_BYTE0_I[5] ? 2'h2 : 2'h1) : 2'h0;
		nxt_st.pair_sel  = op[5:4];
		nxt_st.count     = COUNT_I;
		nxt_st.res16     = MEM_POINTER_I;
		nxt_st.port_addr = PORT_SEL_I;
		nxt_st.port_data = OPERAND_I;
		nxt_st.stk_lo    = STACK_PTR_I;
		nxt_st.stk_hi    = STACK_PTR_I + 16'h0001;
		nxt_st.new_sp    = STACK_PTR_I;
		nxt_st.push_hi   = PAIR_VALUE_I[15:8];
		nxt_st.push_lo   = PAIR_VALUE_I[7:0];
		nxt_st.pc_target = PC_I;
		if (bitp)
		begin
			t_reg = cidt_pkg::T_8;
			t_mem = cidt_pkg::T_15;
			t_idx = cidt_pkg::T_23;
			case (op[7:6])
				2'h0: cls = cidt_pkg::CLS_ROT_SHIFT;
				2'h2: cls = cidt_pkg::CLS_BIT_CLEAR;
				2'h3: cls = cidt_pkg::CLS_BIT_SET;
				default: cls = cidt_pkg::CLS_NONE;
			endcase
		end
		else if (ext)
		begin
			case (op)
				cidt_pkg::EXT_INTERRUPT_RETURN_OP: cls = cidt_pkg::CLS_INTERRUPT_RETURN_OP;
				cidt_pkg::EXT_NMI_RETURN_OP: cls = cidt_pkg::CLS_NMI_RETURN_OP;
				cidt_pkg::EXT_DIGIT_L, cidt_pkg::EXT_DIGIT_R: cls = cidt_pkg::CLS_DIGIT_ROT;
				cidt_pkg::EXT_OUT_UP1, cidt_pkg::EXT_OUT_DN1,
				cidt_pkg::EXT_OUT_UPR, cidt_pkg::EXT_OUT_DNR: cls = cidt_pkg::CLS_BLK_OUT;
				default:
				begin
					if (op[7:6] == 2'h1 && op[2:0] == 3'h1)
						cls = cidt_pkg::CLS_OUT_C;
					else if (op[7:6] == 2'h1 && op[3:0] == 4'h2)
						cls = cidt_pkg::CLS_SBC16;
				end
			endcase
		end
		else
		begin
			case (op)
				cidt_pkg::OPC_OUT_N:     cls = cidt_pkg::CLS_OUT_N;
				cidt_pkg::OPC_RET:       cls = cidt_pkg::CLS_RET;
				cidt_pkg::OPC_CARRY_SET: cls = cidt_pkg::CLS_SCF;
				cidt_pkg::OPC_ACC_ROTATE_LEFT_CIRCULAR, cidt_pkg::OPC_ACC_ROTATE_RIGHT_CIRCULAR,
				cidt_pkg::OPC_RLA, cidt_pkg::OPC_RRA: cls = cidt_pkg::CLS_ACC_ROT;
				cidt_pkg::OPC_OR_N:      cls = cidt_pkg::CLS_OR;
				cidt_pkg::OPC_XOR_N:     cls = cidt_pkg::CLS_XOR;
				cidt_pkg::OPC_SUB_N:     cls = cidt_pkg::CLS_SUB;
				cidt_pkg::OPC_SBC_N:     cls = cidt_pkg::CLS_SBC8;
				default:
				begin
					if (op[7:6] == 2'h2)
					begin
						case (op[5:3])
							3'h6: cls = cidt_pkg::CLS_OR;
							3'h5: cls = cidt_pkg::CLS_XOR;
							3'h2: cls = cidt_pkg::CLS_SUB;
							3'h3: cls = cidt_pkg::CLS_SBC8;
							default: cls = cidt_pkg::CLS_NONE;
						endcase
					end
					else if (op[7:6] == 2'h3 && op[3:0] == 4'h1)
						cls = cidt_pkg::CLS_POP;
					else if (op[7:6] == 2'h3 && op[3:0] == 4'h5)
						cls = cidt_pkg::CLS_PUSH;
					else if (op[7:6] == 2'h3 && op[2:0] == 3'h0)
						cls = cidt_pkg::CLS_RET_CC;
					else if (op[7:6] == 2'h3 && op[2:0] == 3'h7)
						cls = cidt_pkg::CLS_RST;
				end
			endcase
			// Only the memory-operand forms and the pop and push of pair field 2 may follow an index prefix.
			if (idx && !((cls == cidt_pkg::CLS_POP || cls == cidt_pkg::CLS_PUSH) && op[5:4] == 2'h2)
			    && !(op[7:6] == 2'h2 && op[2:0] == cidt_pkg::REG_MEM))
				cls = cidt_pkg::CLS_NONE;
		end
		if (cls == cidt_pkg::CLS_ACC_ROT)
			sub = {1'b0, op[4:3]};
		else if (cls == cidt_pkg::CLS_DIGIT_ROT)
			sub = {2'h0, op[3]};
		nxt_st.cls     = cls;
		nxt_st.known   = (cls != cidt_pkg::CLS_NONE);
		nxt_st.res     = alu_res;
		nxt_st.mem_res = alu_res2;
		nxt_st.flags   = alu_flags;
		case (cls)
			cidt_pkg::CLS_OR, cidt_pkg::CLS_XOR, cidt_pkg::CLS_SUB, cidt_pkg::CLS_SBC8:
			begin
				nxt_st.mask    = 8'hd7;
				nxt_st.mem_op  = op[7:6] == 2'h2 && op[2:0] == cidt_pkg::REG_MEM;
				nxt_st.reg_sel = (op[7:6] == 2'h3) ? 3'h7 : op[2:0];
				if (idx)
				begin
					nxt_st.len = 3'h3;
					nxt_st.tst = t_idx;
				end
				else if (op[7:6] == 2'h3)
				begin
					nxt_st.len = 3'h2;
					nxt_st.tst = t_mem;
				end
				else
					nxt_st.tst = nxt_st.mem_op ? t_mem : t_reg;
			end
			cidt_pkg::CLS_ROT_SHIFT, cidt_pkg::CLS_BIT_CLEAR, cidt_pkg::CLS_BIT_SET:
			begin
				nxt_st.mask = (cls == cidt_pkg::CLS_ROT_SHIFT) ? 8'hd7 : 8'h00;
				nxt_st.len  = idx ? 3'h4 : 3'h2;
				nxt_st.tst  = idx ? t_idx : (nxt_st.mem_op ? t_mem : t_reg);
			end
			cidt_pkg::CLS_SBC16:
			begin
				nxt_st.mask  = 8'hd7;
				nxt_st.len   = 3'h2;
				nxt_st.tst   = cidt_pkg::T_15;
				nxt_st.res16 = alu_res16;
			end
			cidt_pkg::CLS_SCF, cidt_pkg::CLS_ACC_ROT:
			begin
				nxt_st.mask = 8'h13;
				nxt_st.tst  = cidt_pkg::T_4;
			end
			cidt_pkg::CLS_DIGIT_ROT:
			begin
				nxt_st.mask   = 8'hd6;
				nxt_st.len    = 3'h2;
				nxt_st.tst    = cidt_pkg::T_18;
				nxt_st.mem_op = 1'b1;
			end
			cidt_pkg::CLS_OUT_C:
			begin
				nxt_st.len     = 3'h2;
				nxt_st.tst     = cidt_pkg::T_12;
				nxt_st.reg_sel = op[5:3];
				nxt_st.port_wr = 1'b1;
			end
			cidt_pkg::CLS_OUT_N:
			begin
				nxt_st.len       = 3'h2;
				nxt_st.tst       = cidt_pkg::T_11;
				nxt_st.port_wr   = 1'b1;
				nxt_st.port_addr = INSN_BYTE1_I;
				nxt_st.port_data = ACC_I;
			end
			cidt_pkg::CLS_BLK_OUT:
			begin
				nxt_st.len       = 3'h2;
				nxt_st.mem_op    = 1'b1;
				nxt_st.port_wr   = 1'b1;
				nxt_st.count     = cnt;
				nxt_st.res16     = op[3] ? (MEM_POINTER_I - 16'h0001) : (MEM_POINTER_I + 16'h0001);
				nxt_st.repeat_on = op[4] && (cnt != 8'h00);
				nxt_st.tst       = nxt_st.repeat_on ? cidt_pkg::T_21 : cidt_pkg::T_16;
				nxt_st.mask      = 8'h42;
				nxt_st.flags[cidt_pkg::FLG_Z] = op[4] ? 1'b1 : (cnt == 8'h00);
				nxt_st.flags[cidt_pkg::FLG_N] = 1'b1;
			end
			cidt_pkg::CLS_POP, cidt_pkg::CLS_RET, cidt_pkg::CLS_RET_CC,
			cidt_pkg::CLS_INTERRUPT_RETURN_OP, cidt_pkg::CLS_NMI_RETURN_OP:
			begin
				nxt_st.stk_rd = 1'b1;
				nxt_st.new_sp = STACK_PTR_I + 16'h0002;
				if (cls == cidt_pkg::CLS_POP)
				begin
					nxt_st.len = idx ? 3'h2 : 3'h1;
					nxt_st.tst = idx ? cidt_pkg::T_14 : cidt_pkg::T_10;
				end
				else if (cls == cidt_pkg::CLS_RET_CC && !cond_true(op[5:3], FLAGS_I))
				begin
					nxt_st.stk_rd = 1'b0;
					nxt_st.new_sp = STACK_PTR_I;
					nxt_st.tst    = cidt_pkg::T_5;
				end
				else
				begin
					nxt_st.pc_load  = 1'b1;
					nxt_st.pc_stack = 1'b1;
					nxt_st.len      = (cls == cidt_pkg::CLS_INTERRUPT_RETURN_OP || cls == cidt_pkg::CLS_NMI_RETURN_OP) ? 3'h2 : 3'h1;
					nxt_st.tst      = (cls == cidt_pkg::CLS_RET) ? cidt_pkg::T_10 :
					                  ((cls == cidt_pkg::CLS_RET_CC) ? cidt_pkg::T_11 : cidt_pkg::T_14);
				end
			end
			cidt_pkg::CLS_PUSH, cidt_pkg::CLS_RST:
			begin
				nxt_st.stk_wr = 1'b1;
				nxt_st.stk_hi = STACK_PTR_I - 16'h0001;
				nxt_st.stk_lo = STACK_PTR_I - 16'h0002;
				nxt_st.new_sp = STACK_PTR_I - 16'h0002;
				if (cls == cidt_pkg::CLS_PUSH)
				begin
					nxt_st.len = idx ? 3'h2 : 3'h1;
					nxt_st.tst = idx ? cidt_pkg::T_15 : cidt_pkg::T_11;
				end
				else
				begin
					nxt_st.tst       = cidt_pkg::T_11;
					nxt_st.push_hi   = PC_I[15:8];
					nxt_st.push_lo   = PC_I[7:0];
					nxt_st.pc_load   = 1'b1;
					nxt_st.pc_target = {10'h000, op[5:3], 3'h0};
				end
			end
			default:
			begin
				nxt_st.tst = cidt_pkg::T_4;
			end
		endcase
		if (!INSN_VALID_I)
		begin
			nxt_st.port_wr = 1'b0;
			nxt_st.stk_rd  = 1'b0;
			nxt_st.stk_wr  = 1'b0;
			nxt_st.pc_load = 1'b0;
			nxt_st.mask    = 8'h00;
		end
	end

	always_ff @(posedge CLK_SYS_I or posedge RESET_I)
	begin
		if (RESET_I)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	assign DONE_O          = st_ff.done;
	assign KNOWN_O         = st_ff.known;
	assign CLASS_O         = st_ff.cls;
	assign LENGTH_O        = st_ff.len;
	assign TSTATES_O       = st_ff.tst;
	assign REG_SEL_O       = st_ff.reg_sel;
	assign MEM_OPERAND_O   = st_ff.mem_op;
	assign INDEX_SEL_O     = st_ff.idx_sel;
	assign PAIR_SEL_O      = st_ff.pair_sel;
	assign RESULT_O        = st_ff.res;
	assign MEM_RESULT_O    = st_ff.mem_res;
	assign RESULT16_O      = st_ff.res16;
	assign FLAGS_O         = st_ff.flags;
	assign FLAG_MASK_O     = st_ff.mask;
	assign COUNT_O         = st_ff.count;
	assign REPEAT_O        = st_ff.repeat_on;
	assign PORT_WRITE_O    = st_ff.port_wr;
	assign PORT_ADDR_O     = st_ff.port_addr;
	assign PORT_DATA_O     = st_ff.port_data;
	assign STACK_READ_O    = st_ff.stk_rd;
	assign STACK_WRITE_O   = st_ff.stk_wr;
	assign STACK_LO_ADDR_O = st_ff.stk_lo;
	assign STACK_HI_ADDR_O = st_ff.stk_hi;
	assign PUSH_HI_DATA_O  = st_ff.push_hi;
	assign PUSH_LO_DATA_O  = st_ff.push_lo;
	assign NEW_SP_O        = st_ff.new_sp;
	assign PC_LOAD_O       = st_ff.pc_load;
	assign PC_FROM_STACK_O = st_ff.pc_stack;
	assign PC_TARGET_O     = st_ff.pc_target;
endmodule : cidt_decode_top
`default_nettype wire

// ==== logic/cidt_pkg.sv ====
// Shared constants and types for the instruction decode tail block.
package cidt_pkg;

	typedef enum logic [4:0] {
		CLS_NONE, CLS_OR, CLS_XOR, CLS_SUB, CLS_SBC8, CLS_SBC16, CLS_SCF,
		CLS_OUT_N, CLS_OUT_C, CLS_BLK_OUT, CLS_POP, CLS_PUSH, CLS_RET,
		CLS_RET_CC, CLS_INTERRUPT_RETURN_OP, CLS_NMI_RETURN_OP, CLS_RST, CLS_ACC_ROT, CLS_DIGIT_ROT,
		CLS_ROT_SHIFT, CLS_BIT_CLEAR, CLS_BIT_SET
	} cidt_class_t;

	// Prefix bytes.
	localparam logic [7:0] PFX_FIRST_INDEX  = 8'hdd;
	localparam logic [7:0] PFX_SECOND_INDEX = 8'hfd;
	localparam logic [7:0] PFX_EXTENDED     = 8'hed;
	localparam logic [7:0] PFX_BIT_OP       = 8'hcb;

	// Single-byte opcodes.
	localparam logic [7:0] OPC_OUT_N     = 8'hd3;
	localparam logic [7:0] OPC_RET       = 8'hc9;
	localparam logic [7:0] OPC_CARRY_SET = 8'h37;
	localparam logic [7:0] OPC_ACC_ROTATE_LEFT_CIRCULAR      = 8'h07;
	localparam logic [7:0] OPC_ACC_ROTATE_RIGHT_CIRCULAR      = 8'h0f;
	localparam logic [7:0] OPC_RLA       = 8'h17;
	localparam logic [7:0] OPC_RRA       = 8'h1f;
	localparam logic [7:0] OPC_OR_N      = 8'hf6;
	localparam logic [7:0] OPC_XOR_N     = 8'hee;
	localparam logic [7:0] OPC_SUB_N     = 8'hd6;
	localparam logic [7:0] OPC_SBC_N     = 8'hde;

	// Extended opcodes behind the extended prefix.
	localparam logic [7:0] EXT_INTERRUPT_RETURN_OP      = 8'h4d;
	localparam logic [7:0] EXT_NMI_RETURN_OP      = 8'h45;
	localparam logic [7:0] EXT_DIGIT_L   = 8'h6f;
	localparam logic [7:0] EXT_DIGIT_R   = 8'h67;
	localparam logic [7:0] EXT_OUT_UP1   = 8'ha3;
	localparam logic [7:0] EXT_OUT_DN1   = 8'hab;
	localparam logic [7:0] EXT_OUT_UPR   = 8'hb3;
	localparam logic [7:0] EXT_OUT_DNR   = 8'hbb;

	// Register field code that names the memory operand.
	localparam logic [2:0] REG_MEM = 3'h6;

	// Flag bit positions in the flag byte.
	localparam int FLG_S  = 7;
	localparam int FLG_Z  = 6;
	localparam int FLG_H  = 4;
	localparam int FLG_PV = 2;
	localparam int FLG_N  = 1;
	localparam int FLG_C  = 0;

	// Clock-state counts.
	localparam logic [4:0] T_4  = 5'h04;
	localparam logic [4:0] T_5  = 5'h05;
	localparam logic [4:0] T_7  = 5'h07;
	localparam logic [4:0] T_8  = 5'h08;
	localparam logic [4:0] T_10 = 5'h0a;
	localparam logic [4:0] T_11 = 5'h0b;
	localparam logic [4:0] T_12 = 5'h0c;
	localparam logic [4:0] T_14 = 5'h0e;
	localparam logic [4:0] T_15 = 5'h0f;
	localparam logic [4:0] T_16 = 5'h10;
	localparam logic [4:0] T_18 = 5'h12;
	localparam logic [4:0] T_19 = 5'h13;
	localparam logic [4:0] T_21 = 5'h15;
	localparam logic [4:0] T_23 = 5'h17;

endpackage : cidt_pkg

// ==== logic/cidt_alu.sv ====
// Arithmetic, logic, rotate, shift and bit unit of the decode tail.
`timescale 1ns/1ps
`default_nettype none
module cidt_alu (
	input  wire cidt_pkg::cidt_class_t op_i,
	input  wire logic [2:0]            sub_i,
	input  wire logic [7:0]            a_i,
	input  wire logic [7:0]            m_i,
	input  wire logic [7:0]            flags_i,
	input  wire logic [15:0]           hl_i,
	input  wire logic [15:0]           pair_i,
	output logic      [7:0]            res_o,
	output logic      [7:0]            res2_o,
	output logic      [15:0]           res16_o,
	output logic      [7:0]            flags_o
);
	logic       cy;
	logic [8:0] d9;
	logic [4:0] d5;
	logic [16:0] d17;
	logic [12:0] d13;

	always_comb
	begin
		cy      = flags_i[cidt_pkg::FLG_C];
		res_o   = a_i;
		res2_o  = m_i;
		res16_o = hl_i;
		flags_o = flags_i;
		d9      = 9'h000;
		d5      = 5'h00;
		d17     = 17'h00000;
		d13     = 13'h0000;
		case (op_i)
			cidt_pkg::CLS_OR, cidt_pkg::CLS_XOR:
			begin
				res_o = (op_i == cidt_pkg::CLS_OR) ? (a_i | m_i) : (a_i ^ m_i);
				flags_o[cidt_pkg::FLG_C]  = 1'b0;
				flags_o[cidt_pkg::FLG_N]  = 1'b0;
				flags_o[cidt_pkg::FLG_H]  = 1'b0;
			end
			cidt_pkg::CLS_SUB, cidt_pkg::CLS_SBC8:
			begin
				d9 = {1'b0, a_i} - {1'b0, m_i} - {8'h00, (op_i == cidt_pkg::CLS_SBC8) & cy};
				d5 = {1'b0, a_i[3:0]} - {1'b0, m_i[3:0]} - {4'h0, (op_i == cidt_pkg::CLS_SBC8) & cy};
				res_o = d9[7:0];
				flags_o[cidt_pkg::FLG_C] = d9[8];
				flags_o[cidt_pkg::FLG_H] = d5[4];
				flags_o[cidt_pkg::FLG_N] = 1'b1;
			end
			cidt_pkg::CLS_SBC16:
			begin
				d17 = {1'b0, hl_i} - {1'b0, pair_i} - {16'h0000, cy};
				d13 = {1'b0, hl_i[11:0]} - {1'b0, pair_i[11:0]} - {12'h000, cy};
				res16_o = d17[15:0];
				flags_o[cidt_pkg::FLG_S]  = d17[15];
				flags_o[cidt_pkg::FLG_Z]  = (d17[15:0] == 16'h0000);
				flags_o[cidt_pkg::FLG_PV] = (hl_i[15] ^ pair_i[15]) & (hl_i[15] ^ d17[15]);
				flags_o[cidt_pkg::FLG_H]  = d13[12];
				flags_o[cidt_pkg::FLG_N]  = 1'b1;
				flags_o[cidt_pkg::FLG_C]  = d17[16];
			end
			cidt_pkg::CLS_SCF:
			begin
				flags_o[cidt_pkg::FLG_C] = 1'b1;
				flags_o[cidt_pkg::FLG_N] = 1'b0;
				flags_o[cidt_pkg::FLG_H] = 1'b0;
			end
			cidt_pkg::CLS_ACC_ROT, cidt_pkg::CLS_ROT_SHIFT:
			begin
				case (sub_i)
					3'h0: {flags_o[cidt_pkg::FLG_C], res_o} = {m_i[7], m_i[6:0], m_i[7]};
					3'h1: {res_o, flags_o[cidt_pkg::FLG_C]} = {m_i[0], m_i[7:1], m_i[0]};
					3'h2: {flags_o[cidt_pkg::FLG_C], res_o} = {m_i, cy};
					3'h3: {res_o, flags_o[cidt_pkg::FLG_C]} = {cy, m_i};
					3'h4: {flags_o[cidt_pkg::FLG_C], res_o} = {m_i, 1'b0};
					3'h5: {res_o, flags_o[cidt_pkg::FLG_C]} = {m_i[7], m_i};
					3'h7: {res_o, flags_o[cidt_pkg::FLG_C]} = {1'b0, m_i};
					default: {flags_o[cidt_pkg::FLG_C], res_o} = {m_i, 1'b1};
				endcase
				flags_o[cidt_pkg::FLG_N] = 1'b0;
				flags_o[cidt_pkg::FLG_H] = 1'b0;
			end
			cidt_pkg::CLS_DIGIT_ROT:
			begin
				if (sub_i[0])
				begin
					res_o  = {a_i[7:4], m_i[7:4]};
					res2_o = {m_i[3:0], a_i[3:0]};
				end
				else
				begin
					res_o  = {a_i[7:4], m_i[3:0]};
					res2_o = {a_i[3:0], m_i[7:4]};
				end
				flags_o[cidt_pkg::FLG_N] = 1'b0;
				flags_o[cidt_pkg::FLG_H] = 1'b0;
			end
			cidt_pkg::CLS_BIT_CLEAR:
				res_o = m_i & ~(8'h01 << sub_i);
			cidt_pkg::CLS_BIT_SET:
				res_o = m_i | (8'h01 << sub_i);
			default:
				res_o = a_i;
		endcase
		if (op_i inside {cidt_pkg::CLS_OR, cidt_pkg::CLS_XOR, cidt_pkg::CLS_SUB, cidt_pkg::CLS_SBC8,
		    cidt_pkg::CLS_ROT_SHIFT, cidt_pkg::CLS_DIGIT_ROT})
		begin
			flags_o[cidt_pkg::FLG_S] = res_o[7];
			flags_o[cidt_pkg::FLG_Z] = (res_o == 8'h00);
			if (op_i == cidt_pkg::CLS_SUB || op_i == cidt_pkg::CLS_SBC8)
				flags_o[cidt_pkg::FLG_PV] = (a_i[7] ^ m_i[7]) & (a_i[7] ^ res_o[7]);
			else
				flags_o[cidt_pkg::FLG_PV] = ~(^res_o);
		end
	end
endmodule : cidt_alu
`default_nettype wire

// ==== test/cidt_chk.sv ====
// Port assertions for the decode tail.
`timescale 1ns/1ps
`default_nettype none
module cidt_chk (
	input wire logic        CLK_SYS_I,
	input wire logic        RESET_I,
	input wire logic        INSN_VALID_I,
	input wire logic [7:0]  INSN_BYTE0_I,
	input wire logic [7:0]  ACC_I,
	input wire logic [7:0]  OPERAND_I,
	input wire logic [15:0] STACK_PTR_I,
	input wire logic        DONE_O,
	input wire logic [4:0]  TSTATES_O,
	input wire logic [7:0]  RESULT_O,
	input wire logic [7:0]  FLAGS_O,
	input wire logic        PORT_WRITE_O,
	input wire logic [15:0] STACK_LO_ADDR_O,
	input wire logic [15:0] STACK_HI_ADDR_O
);
	default clocking @(posedge CLK_SYS_I); endclocking
	default disable iff (RESET_I);
	sequence s_op(logic [7:0] c);
		INSN_VALID_I && INSN_BYTE0_I == c;
	endsequence
	a_or_result: assert property (s_op(8'hb0) |=> RESULT_O == ($past(ACC_I) | $past(OPERAND_I)))
		else $error("or result wrong");
	a_sub_flag: assert property (s_op(8'h90) |=> FLAGS_O[1] && RESULT_O == $past(ACC_I) - $past(OPERAND_I))
		else $error("subtract wrong");
	a_out_write: assert property (s_op(8'hd3) |=> PORT_WRITE_O && DONE_O && TSTATES_O == 5'h0b)
		else $error("port output wrong");
	a_pop_addr: assert property (s_op(8'hc1) |=> STACK_HI_ADDR_O == $past(STACK_PTR_I) + 16'h1)
		else $error("pop address wrong");
	a_push_addr: assert property (s_op(8'hc5) |=> STACK_LO_ADDR_O == $past(STACK_PTR_I) - 16'h2)
		else $error("push address wrong");
	a_ret_time: assert property (s_op(8'hc9) |=> TSTATES_O == 5'h0a)
		else $error("return time wrong");
	a_carry_force: assert property (s_op(8'h37) |=> FLAGS_O[0] && !FLAGS_O[1] && !FLAGS_O[4])
		else $error("carry force wrong");
	a_rst_push: assert property (s_op(8'hff) |=> STACK_HI_ADDR_O == $past(STACK_PTR_I) - 16'h1)
		else $error("restart push wrong");
endmodule : cidt_chk
bind cidt_decode_top cidt_chk chk (.*);
`default_nettype wire

// ==== test/cidt_mem_model.sv ====
// Memory model that answers the byte at the pointer.
`timescale 1ns/1ps
`default_nettype none
module cidt_mem_model (
	input  wire logic [15:0] addr_i,
	output logic      [7:0]  rd_o
);
	// Contents are a fixed hash of the address.
	assign rd_o = addr_i[15:8] ^ addr_i[7:0] ^ 8'h3c;
endmodule : cidt_mem_model
`default_nettype wire

// ==== test/test_cpu_insn_decode_tail.sv ====
// Self-checking bench for the decode tail.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_count++; \
	$display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module test_cpu_insn_decode_tail;
	logic CLK_SYS_I = 0, RESET_I = 1, INSN_VALID_I = 0;
	logic [7:0] INSN_BYTE0_I = '0, INSN_BYTE1_I = '0, INSN_BYTE2_I = '0, INSN_BYTE3_I = '0;
	logic [7:0] ACC_I = '0, FLAGS_I = '0, PORT_SEL_I = '0, COUNT_I = '0, a, m, e, cn = '0;
	logic [15:0] MEM_POINTER_I = '0, PAIR_VALUE_I = '0, STACK_PTR_I = '0, PC_I = '0;
	logic [31:0] r;
	wire [7:0] OPERAND_I, RESULT_O, MEM_RESULT_O, FLAGS_O, FLAG_MASK_O, COUNT_O;
	wire [7:0] PORT_ADDR_O, PORT_DATA_O, PUSH_HI_DATA_O, PUSH_LO_DATA_O;
	wire DONE_O, KNOWN_O, MEM_OPERAND_O, REPEAT_O, PORT_WRITE_O, STACK_READ_O;
	wire STACK_WRITE_O, PC_LOAD_O, PC_FROM_STACK_O;
	wire [2:0] LENGTH_O, REG_SEL_O;
	wire [4:0] TSTATES_O;
	wire [1:0] INDEX_SEL_O, PAIR_SEL_O;
	wire [15:0] RESULT16_O, STACK_LO_ADDR_O, STACK_HI_ADDR_O, NEW_SP_O, PC_TARGET_O;
	cidt_pkg::cidt_class_t CLASS_O;
	int err_count = 0, n_checks = 0, cyc = 0;
	logic [47:0] tab [24] = '{48'h1303ddb60500, 48'h0c02ed410000, 48'h0b02d3220000,
		48'h0a01c1000000, 48'h0b01c5000000, 48'h0e02dde10000, 48'h0f02fde50000,
		48'h0f02cb860000, 48'h1704ddcb0386, 48'h1704fdcb04c6, 48'h0a01c9000000,
		48'h0e02ed4d0000, 48'h0e02ed450000, 48'h1704ddcb0106, 48'h1202ed6f0000,
		48'h04011f000000, 48'h0b01ff000000, 48'h0f02ed420000, 48'h0702de330000,
		48'h1303fd960200, 48'h0702ee440000, 48'h040137000000, 48'h0f02cb2e0000,
		48'h1704fdcb003e};
	cidt_decode_top uut (.*);
	cidt_mem_model mem (.addr_i(MEM_POINTER_I), .rd_o(OPERAND_I));
	task automatic results();
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : results
	task automatic run(input logic [31:0] w);
		@(posedge CLK_SYS_I);
		r = $urandom;
		{INSN_BYTE0_I, INSN_BYTE1_I, INSN_BYTE2_I, INSN_BYTE3_I} <= w;
		{ACC_I, FLAGS_I, PORT_SEL_I} <= r[31:8];
		COUNT_I <= (cn != 8'h0) ? cn : r[7:0];
		{MEM_POINTER_I, STACK_PTR_I} <= $urandom;
		{PAIR_VALUE_I, PC_I} <= $urandom;
		INSN_VALID_I <= 1'b1;
		@(posedge CLK_SYS_I);
		INSN_VALID_I <= 1'b0;
		#1;
		a = ACC_I;
		m = OPERAND_I;
	endtask : run
	initial
	begin
		forever #10 CLK_SYS_I = ~CLK_SYS_I;
	end
	always @(posedge CLK_SYS_I)
	begin
		cyc++;
		if (cyc == 2000)
		begin
			err_count++;
			results();
		end
	end
	initial
	begin
		r = $urandom(27);
		repeat (2) @(posedge CLK_SYS_I);
		RESET_I <= 1'b0;
		foreach (tab[i])
		begin
			run(tab[i][31:0]);
			`CHK({TSTATES_O, LENGTH_O}, {tab[i][44:40], tab[i][34:32]})
			e = tab[i][31:24];
			`CHK({KNOWN_O, INDEX_SEL_O}, {1'b1, e == 8'hfd, e == 8'hdd})
		end
		for (int i = 0; i < 16; i++)
		begin
			run({8'hb0 ^ {3'h0, i[3], i[3], i[2:0]}, 24'h0});
			e = i[3] ? a ^ m : a | m;
			`CHK({REG_SEL_O, MEM_OPERAND_O}, {i[2:0], i[2:0] == 3'h6})
			`CHK({RESULT_O, FLAGS_O[2]}, {e, ~^e})
			if (!i[3])
				`CHK(FLAGS_O[1:0], 2'h0)
			run({8'hcb, 8'h80 | {1'b0, i[3], i[2:0], 3'h0}, 16'h0});
			e = 8'h1 << i[2:0];
			`CHK({RESULT_O, FLAG_MASK_O}, {i[3] ? m | e : m & ~e, 8'h00})
		end
		for (int i = 0; i < 8; i++)
		begin
			run({8'h90 | {4'h0, i[0], 3'h0}, 24'h0});
			e = a - m - (i[0] & FLAGS_I[0]);
			`CHK({RESULT_O, FLAGS_O[2:1]}, {e, a[7] != m[7] && e[7] != a[7], 1'b1})
			run({8'hc0 | {4'h0, i[0], 3'h0}, 24'h0});
			`CHK(TSTATES_O, (FLAGS_I[6] ^ i[0]) ? 5 : 11)
			`CHK({STACK_READ_O, PC_FROM_STACK_O}, {2{FLAGS_I[6] == i[0]}})
			`CHK(NEW_SP_O, STACK_PTR_I + {FLAGS_I[6] == i[0], 1'b0})
			cn = i[0] ? 8'h2 : 8'h1;
			run({8'hed, 8'ha3 | {3'h0, i[2:1], 3'h0}, 16'h0});
			cn = 8'h0;
			`CHK(TSTATES_O, (i[2] && COUNT_I == 8'h2) ? 21 : 16)
			`CHK({COUNT_O, FLAGS_O[6], FLAGS_O[1]}, {COUNT_I - 8'h1, i[2] || COUNT_I == 8'h1, 1'b1})
			`CHK(RESULT16_O, i[1] ? MEM_POINTER_I - 16'h1 : MEM_POINTER_I + 16'h1)
			`CHK({REPEAT_O, PORT_DATA_O}, {i[2] && COUNT_I == 8'h2, m})
		end
		run(32'h07000000);
		`CHK({RESULT_O, FLAGS_O[0]}, {a[6:0], a[7], a[7]})
		`CHK({FLAGS_O[7:2], FLAGS_O[1]}, {FLAGS_I[7:5], 1'b0, FLAGS_I[3:2], 1'b0})
		run(32'hcb000000);
		`CHK({RESULT_O, FLAGS_O[2:0]}, {m[6:0], m[7], ~^m, 1'b0, m[7]})
		run(32'hed410000);
		`CHK({PORT_WRITE_O, PORT_ADDR_O, PORT_DATA_O}, {1'b1, PORT_SEL_I, m})
		run(32'he1000000);
		`CHK({STACK_READ_O, PAIR_SEL_O, STACK_LO_ADDR_O}, {3'h6, STACK_PTR_I})
		run(32'hd5000000);
		`CHK({STACK_WRITE_O, PUSH_HI_DATA_O, PUSH_LO_DATA_O}, {1'b1, PAIR_VALUE_I})
		run(32'hef000000);
		`CHK({PC_LOAD_O, PC_TARGET_O, PUSH_LO_DATA_O}, {1'b1, 16'h0028, PC_I[7:0]})
		run(32'hed6f0000);
		`CHK({RESULT_O, MEM_RESULT_O, FLAG_MASK_O}, {a[7:4], m, a[3:0], 8'hd6})
		run(32'hed670000);
		`CHK({RESULT_O, MEM_RESULT_O}, {a[7:4], m[3:0], a[3:0], m[7:4]})
		run(32'hed520000);
		`CHK(RESULT16_O, MEM_POINTER_I - PAIR_VALUE_I - FLAGS_I[0])
		run(32'hddb00000);
		`CHK({KNOWN_O, CLASS_O, FLAG_MASK_O}, {1'b0, cidt_pkg::CLS_NONE, 8'h00})
		results();
	end
endmodule : test_cpu_insn_decode_tail
`default_nettype wire
